// File: dnvba_top.sv
// module: register and sequencing logic for data nonvolatile byte access
// Notes on behaviour
// - write starts only after 55h, then AAh, then start bit set
// - start bit cannot be set while the arm bit is clear
// - one write setting both arm and start while arm is clear sets arm but not start
// - hardware never clears the arm bit; software only
// - while writing, control, pointer and buffer writes are ignored
// - write end clears start bit and sets the done flag
// - done flag stays set until software clears it
// - read start with both space selects clear loads buffer from array in the same cycle
// - buffer keeps read byte until next read or software write
`default_nettype none
module dnvba_top
    import dnvba_pkg::*;
#(
    parameter int WRITE_CYCLES = DNVBA_WRITE_CYC
)
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ptr_we,
    input  wire logic                    buf_we,
    input  wire logic                    ctrl_we,
    input  wire logic                    unlock_we,
    input  wire logic                    done_clr,
    input  wire logic [DNVBA_DATA_W-1:0] wdata,
    output logic      [DNVBA_ADDR_W-1:0] nv_location_pointer,
    output logic      [DNVBA_DATA_W-1:0] nv_byte_buffer,
    output logic      [7:0]              nv_control_reg,
    output logic                         program_done_flag
);
    logic                    program_arm;
    logic                    write_start;
    logic                    code_space_select;
    logic                    config_space_select;
    logic [DNVBA_CNT_W-1:0]  count;
    dnvba_unlock_type        unlock;
    logic [DNVBA_ADDR_W-1:0] next_ptr;
    logic [DNVBA_DATA_W-1:0] next_buf;
    logic                    next_arm;
    logic                    next_start;
    logic                    next_code;
    logic                    next_cfg;
    logic                    next_done;
    logic [DNVBA_CNT_W-1:0]  next_count;
    dnvba_unlock_type        next_unlock;
    logic                    cell_wr;
    logic [DNVBA_DATA_W-1:0] cell_rdata;
    logic                    data_space;
    logic                    start_req;
    logic                    write_end;

    dnvba_cell_array u_cells (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (cell_wr),
        .addr  (nv_location_pointer),
        .wdata (nv_byte_buffer),
        .rdata (cell_rdata)
    );

    // status view of the control register
    always_comb
    begin
        nv_control_reg                   = DNVBA_CTRL_RESET;
        nv_control_reg[DNVBA_BIT_START]  = write_start;
        nv_control_reg[DNVBA_BIT_ARM]    = program_arm;
        nv_control_reg[DNVBA_BIT_CFG]    = config_space_select;
        nv_control_reg[DNVBA_BIT_CODE]   = code_space_select;
    end

    assign data_space = !code_space_select && !config_space_select;
    // start needs armed state already held, open unlock, no write in progress
    assign start_req  = ctrl_we && wdata[DNVBA_BIT_START] && program_arm
                        && (unlock == DNVBA_UNLOCK_OPEN) && !write_start;
    assign write_end  = write_start && (count == DNVBA_CNT_W'(1));
    assign cell_wr    = write_end && data_space;

    // next state of registers, unlock tracker and write timer
    always_comb
    begin
        next_ptr    = nv_location_pointer;
        next_buf    = nv_byte_buffer;
        next_arm    = program_arm;
        next_start  = write_start;
        next_code   = code_space_select;
        next_cfg    = config_space_select;
        next_done   = program_done_flag;
        next_count  = count;
        next_unlock = unlock;
        // any pointer, buffer, control or wrong key write drops the unlock; a done clear does not
        if (ptr_we || buf_we || ctrl_we)
        begin
            next_unlock = DNVBA_UNLOCK_IDLE;
        end
        if (unlock_we)
        begin
            if (wdata == DNVBA_KEY_FIRST)
            begin
                next_unlock = DNVBA_UNLOCK_HALF;
            end
            else if ((wdata == DNVBA_KEY_SECOND) && (unlock == DNVBA_UNLOCK_HALF))
            begin
                next_unlock = DNVBA_UNLOCK_OPEN;
            end
            else
            begin
                next_unlock = DNVBA_UNLOCK_IDLE;
            end
        end
        if (!write_start)
        begin
            // registers writable only while idle
            if (ptr_we)
            begin
                next_ptr = wdata;
            end
            if (buf_we)
            begin
                next_buf = wdata;
            end
            if (ctrl_we)
            begin
                next_arm  = wdata[DNVBA_BIT_ARM];
                next_code = wdata[DNVBA_BIT_CODE];
                next_cfg  = wdata[DNVBA_BIT_CFG];
                if (wdata[DNVBA_BIT_READ] && !wdata[DNVBA_BIT_CODE]
                    && !wdata[DNVBA_BIT_CFG])
                begin
                    next_buf = cell_rdata;
                end
            end
            if (start_req)
            begin
                next_start = 1'b1;
                next_count = DNVBA_CNT_W'(WRITE_CYCLES);
            end
        end
        else
        begin
            next_count = count - DNVBA_CNT_W'(1);
            if (write_end)
            begin
                next_start = 1'b0;
            end
        end
        // set wins over a clear in the same cycle
        if (done_clr)
        begin
            next_done = 1'b0;
        end
        if (write_end)
        begin
            next_done = 1'b1;
        end
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_location_pointer <= '0;
            nv_byte_buffer      <= DNVBA_BYTE_RESET;
            program_arm         <= 1'b0;
            write_start         <= 1'b0;
            code_space_select   <= 1'b0;
            config_space_select <= 1'b0;
            program_done_flag   <= 1'b0;
            count               <= '0;
            unlock              <= DNVBA_UNLOCK_IDLE;
        end
        else
        begin
            nv_location_pointer <= next_ptr;
            nv_byte_buffer      <= next_buf;
            program_arm         <= next_arm;
            write_start         <= next_start;
            code_space_select   <= next_code;
            config_space_select <= next_cfg;
            program_done_flag   <= next_done;
            count               <= next_count;
            unlock              <= next_unlock;
        end
    end

    // checks
    property p_no_start_unarmed;
        @(posedge clk) disable iff (!rst_n)
        $rose(write_start) |-> $past(program_arm) && program_arm;
    endproperty
    a_no_start_unarmed: assert property (p_no_start_unarmed) else $error("start without arm");

    property p_start_needs_key;
        @(posedge clk) disable iff (!rst_n)
        $rose(write_start) |-> $past(unlock == DNVBA_UNLOCK_OPEN);
    endproperty
    a_start_needs_key: assert property (p_start_needs_key) else $error("start without key");

    property p_arm_kept;
        @(posedge clk) disable iff (!rst_n)
        $fell(program_arm) |-> $past(ctrl_we && !write_start);
    endproperty
    a_arm_kept: assert property (p_arm_kept) else $error("arm cleared by hardware");

    property p_locked;
        @(posedge clk) disable iff (!rst_n)
        write_start && !write_end |=> $stable(nv_location_pointer)
            && $stable(nv_byte_buffer) && $stable(program_arm);
    endproperty
    a_locked: assert property (p_locked) else $error("register changed while busy");

    property p_end;
        @(posedge clk) disable iff (!rst_n)
        write_end |=> !write_start && program_done_flag;
    endproperty
    a_end: assert property (p_end) else $error("write end not reported");

    property p_done_hold;
        @(posedge clk) disable iff (!rst_n)
        program_done_flag && !done_clr |=> program_done_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag lost");

    property p_read;
        @(posedge clk) disable iff (!rst_n)
        ctrl_we && !write_start && wdata[DNVBA_BIT_READ] && !wdata[DNVBA_BIT_CODE]
            && !wdata[DNVBA_BIT_CFG] |=> nv_byte_buffer == $past(cell_rdata);
    endproperty
    a_read: assert property (p_read) else $error("read data not loaded");

    // busy only ends at the last count, one count per cycle
    property p_busy_len;
        @(posedge clk) disable iff (!rst_n)
        write_start && !write_end
            |=> write_start && (count == $past(count) - DNVBA_CNT_W'(1));
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write too short");

    property p_busy_load;
        @(posedge clk) disable iff (!rst_n)
        $rose(write_start) |-> count == DNVBA_CNT_W'(WRITE_CYCLES);
    endproperty
    a_busy_load: assert property (p_busy_load) else $error("write timer not loaded");

    property p_bad_key;
        @(posedge clk) disable iff (!rst_n)
        unlock_we && wdata != DNVBA_KEY_FIRST && wdata != DNVBA_KEY_SECOND
            |=> unlock == DNVBA_UNLOCK_IDLE;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key kept unlock");

    c_write: cover property (@(posedge clk) disable iff (!rst_n) write_end);
    c_read: cover property (@(posedge clk) disable iff (!rst_n)
        ctrl_we && wdata[DNVBA_BIT_READ]);
    c_clear_race: cover property (@(posedge clk) disable iff (!rst_n) write_end && done_clr);
endmodule : dnvba_top
`default_nettype wire

// File: dnvba_pkg.sv
// package: constants for the data nonvolatile byte access block
`default_nettype none
package dnvba_pkg;
    localparam int          DNVBA_ADDR_W      = 8;
    localparam int          DNVBA_DATA_W      = 8;
    localparam int          DNVBA_DEPTH       = 256;
    localparam logic [7:0]  DNVBA_KEY_FIRST   = 8'h55;
    localparam logic [7:0]  DNVBA_KEY_SECOND  = 8'hAA;
    // control register field positions
    localparam int          DNVBA_BIT_READ    = 0;
    localparam int          DNVBA_BIT_START   = 1;
    localparam int          DNVBA_BIT_ARM     = 2;
    localparam int          DNVBA_BIT_CFG     = 6;
    localparam int          DNVBA_BIT_CODE    = 7;
    localparam logic [7:0]  DNVBA_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  DNVBA_BYTE_RESET  = 8'h00;
    // write cycle time and its count at 250 MHz
    localparam int          DNVBA_WRITE_NS    = 4000;
    localparam int          DNVBA_CLK_NS      = 4;
    localparam int          DNVBA_WRITE_CYC   = (DNVBA_WRITE_NS + DNVBA_CLK_NS - 1) / DNVBA_CLK_NS;
    localparam int          DNVBA_CNT_W       = 16;
    typedef enum logic [1:0] {DNVBA_UNLOCK_IDLE, DNVBA_UNLOCK_HALF, DNVBA_UNLOCK_OPEN}
        dnvba_unlock_type;
endpackage : dnvba_pkg
`default_nettype wire

// File: dnvba_cell_array.sv
// module: flip-flop byte array holding the data nonvolatile contents
`default_nettype none
module dnvba_cell_array
    import dnvba_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    wr_en,
    input  wire logic [DNVBA_ADDR_W-1:0] addr,
    input  wire logic [DNVBA_DATA_W-1:0] wdata,
    output logic      [DNVBA_DATA_W-1:0] rdata
);
    logic [DNVBA_DATA_W-1:0] cells      [DNVBA_DEPTH];
    logic [DNVBA_DATA_W-1:0] next_cells [DNVBA_DEPTH];

    // one entry per location, loaded only on a programmed write
    genvar gi;
    generate
        for (gi = 0; gi < DNVBA_DEPTH; gi++)
        begin : g_cell
            always_comb
            begin
                next_cells[gi] = cells[gi];
                if (wr_en && (addr == DNVBA_ADDR_W'(gi)))
                begin
                    next_cells[gi] = wdata;
                end
            end
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cells[gi] <= DNVBA_BYTE_RESET;
                end
                else
                begin
                    cells[gi] <= next_cells[gi];
                end
            end
        end
    endgenerate

    // combinational read port
    assign rdata = cells[addr];
endmodule : dnvba_cell_array
`default_nettype wire

// File: dnvba_sw_model.sv
// partner: software side that writes the special function registers
`default_nettype none
module dnvba_sw_model
    import dnvba_pkg::*;
(
    input  wire logic                    clk,
    output wire logic                    ptr_we,
    output wire logic                    buf_we,
    output wire logic                    ctrl_we,
    output wire logic                    unlock_we,
    output wire logic                    done_clr,
    output logic      [DNVBA_DATA_W-1:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] stb;
    // one strobe per kind: 0 pointer, 1 buffer, 2 control, 3 unlock, 4 done clear
    assign {done_clr, unlock_we, ctrl_we, buf_we, ptr_we} = stb;
    initial
    begin
        stb   = 5'h00;
        wdata = 8'h00;
    end
    // one-cycle register write; released data shows the inverse, never the old value
    task automatic wr(input logic [2:0] k, input logic [7:0] v);
        @(negedge clk);
        stb   = 5'h01 << k;
        wdata = v;
        @(negedge clk);
        stb   = 5'h00;
        wdata = ~v;
    endtask : wr
    // unlock keys 55h then AAh are written first, space selects stay clear in 8'h06
    task automatic prog_byte;
        wr(3'h3, DNVBA_KEY_FIRST);
        wr(3'h3, DNVBA_KEY_SECOND);
        wr(3'h2, 8'h06);
    endtask : prog_byte
endmodule : dnvba_sw_model
`default_nettype wire

// File: tb_top.sv
// testbench: register table walk, then write, busy lock, read and reset cases
`default_nettype none
module tb_top;
    import dnvba_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 12;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    wire logic  ptr_we, buf_we, ctrl_we, unlock_we, done_clr;
    logic [7:0] wdata, ptr, bytebuf, ctrl;
    logic       done;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         n;
    // rows: kind, value, expected pointer, buffer, control
    logic [39:0] rows [12] = '{
        40'h00_5A_5A_00_00, 40'h01_3C_5A_3C_00, 40'h02_06_5A_3C_04, 40'h02_06_5A_3C_04,
        40'h03_55_5A_3C_04, 40'h03_11_5A_3C_04, 40'h03_AA_5A_3C_04, 40'h02_06_5A_3C_04,
        40'h03_55_5A_3C_04, 40'h00_77_77_3C_04, 40'h03_AA_77_3C_04, 40'h02_06_77_3C_04};
    always #2 clk = ~clk;
    dnvba_sw_model dnvba_sw_model_i (
        .clk       (clk),
        .ptr_we    (ptr_we),
        .buf_we    (buf_we),
        .ctrl_we   (ctrl_we),
        .unlock_we (unlock_we),
        .done_clr  (done_clr),
        .wdata     (wdata)
    );
    dnvba_top #(.WRITE_CYCLES(WC)) dnvba_top_i (
        .clk                 (clk),
        .rst_n               (rst_n),
        .ptr_we              (ptr_we),
        .buf_we              (buf_we),
        .ctrl_we             (ctrl_we),
        .unlock_we           (unlock_we),
        .done_clr            (done_clr),
        .wdata               (wdata),
        .nv_location_pointer (ptr),
        .nv_byte_buffer      (bytebuf),
        .nv_control_reg      (ctrl),
        .program_done_flag   (done)
    );
    // compare one value with its expectation
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            finish_test();
        end
    end
    // main sequence
    initial
    begin
        repeat (6) @(negedge clk);
        chk({ptr, bytebuf, ctrl, 7'h00, done}, 32'h0);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            dnvba_sw_model_i.wr(rows[i][34:32], rows[i][31:24]);
            chk(ptr, rows[i][23:16]);
            chk(bytebuf, rows[i][15:8]);
            chk(ctrl, rows[i][7:0]);
        end
        $display("test register rows done");
        dnvba_sw_model_i.prog_byte();
        chk(ctrl, 8'h06);
        dnvba_sw_model_i.wr(3'h0, 8'h11);
        dnvba_sw_model_i.wr(3'h1, 8'h99);
        dnvba_sw_model_i.wr(3'h2, 8'h00);
        chk({ptr, bytebuf}, 16'h773C);
        n = 6;
        while (ctrl[1] === 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, WC);
        chk(ctrl, 8'h04);
        chk({7'h00, done}, 8'h01);
        repeat (3) @(negedge clk);
        chk({7'h00, done}, 8'h01);
        dnvba_sw_model_i.wr(3'h4, 8'h00);
        chk({7'h00, done}, 8'h00);
        $display("test byte write done");
        dnvba_sw_model_i.wr(3'h1, 8'h5A);
        dnvba_sw_model_i.wr(3'h2, 8'h05);
        chk(bytebuf, 8'h3C);
        dnvba_sw_model_i.wr(3'h0, 8'h10);
        dnvba_sw_model_i.wr(3'h2, 8'h85);
        chk(bytebuf, 8'h3C);
        dnvba_sw_model_i.wr(3'h2, 8'h05);
        chk(bytebuf, 8'h00);
        dnvba_sw_model_i.wr(3'h1, 8'hE1);
        chk(bytebuf, 8'hE1);
        $display("test byte read done");
        dnvba_sw_model_i.wr(3'h2, 8'h00);
        dnvba_sw_model_i.wr(3'h3, DNVBA_KEY_FIRST);
        dnvba_sw_model_i.wr(3'h3, DNVBA_KEY_SECOND);
        dnvba_sw_model_i.wr(3'h2, 8'h02);
        chk(ctrl, 8'h00);
        dnvba_sw_model_i.prog_byte();
        chk(ctrl, 8'h04);
        $display("test arm guard done");
        rst_n = 1'b0;
        @(negedge clk);
        chk({ptr, bytebuf, ctrl}, 24'h0);
        rst_n = 1'b1;
        dnvba_sw_model_i.wr(3'h0, 8'h33);
        chk(ptr, 8'h33);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
